// *** lhfs_pkg.sv ***
// Overview of operation
// - Send heartbeat continuously; time/date each second.
// - Send on one port, expect return other.
// - Also send heartbeat opposite direction.
// - Own faults include ring and offline.
// - Fault shows text, indicator, tone, drops relay.
// - Redundancy fault only when redundant pair.
// - Alarm shows text, indicator, alarm tone.
// - Faults and alarms latched until reset.
// - Reset clears only when displayed conditions inactive.
// - Active alarms survive a controller reset.
// - Event log holds up to 4095 entries.
// - Start logic cycle every hundred milliseconds.
// - Evaluate pages in program order.
// - Unfinished logic resumes; restart after completion.
// - Show offline indication for silent devices.
package lhfs_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FAULT = 8'h08;
  localparam logic [7:0] ADDR_ALARM = 8'h0c;
  localparam logic [7:0] ADDR_TIME = 8'h10;
  localparam logic [7:0] ADDR_LOGCNT = 8'h14;
  localparam logic [7:0] ADDR_LOGIDX = 8'h18;
  localparam logic [7:0] ADDR_LOGDATA = 8'h1c;
  localparam logic [7:0] ADDR_PAGES = 8'h20;
  localparam logic [7:0] ADDR_OFFLINE = 8'h24;
  // CTRL fields
  localparam int CTRL_REDUND_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Fault bit positions
  localparam int FLT_CTRL = 0;
  localparam int FLT_OFFLINE = 1;
  localparam int FLT_RING = 2;
  localparam int FLT_REDUND = 3;
  localparam int FLT_DEVICE = 4;
  localparam int FLT_W = 5;
  localparam int ALM_W = 8;
  localparam int NDEV = 8;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int HB_PERIOD_US = 1000;
  localparam int HB_CYC = HB_PERIOD_US * CLK_MHZ;
  localparam int HB_PER_SEC = 1000;
  localparam int RING_TMO_US = 500;
  localparam int RING_TMO_CYC = RING_TMO_US * CLK_MHZ;
  localparam int LOGIC_PERIOD_MS = 100;
  localparam int LOGIC_CYC = LOGIC_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int DEV_TMO_MS = 3000;
  localparam int DEV_TMO_TICKS = DEV_TMO_MS * 1000 / HB_PERIOD_US;
  localparam int LOG_DEPTH = 4095;
  localparam int LOG_AW = 12;
  typedef enum logic [1:0] {
    LHFS_HB_IDLE = 2'b00,
    LHFS_HB_WAIT = 2'b01,
    LHFS_HB_FAIL = 2'b10
  } lhfs_hb_e;
endpackage

// *** lhfs_log_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// Event log write and read port between supervisor and log store
interface lhfs_log_if;
  logic wr;
  logic [31:0] wdata;
  logic [11:0] ridx;
  logic [31:0] rdata;
  logic [11:0] count;
  modport master(output wr, output wdata, output ridx, input rdata, input count);
  modport store(input wr, input wdata, input ridx, output rdata, output count);
endinterface
`default_nettype wire

// *** lhfs_log.sv ***
`timescale 1ns/1ns
`default_nettype none
// Event log kept in flip-flops; the oldest records are kept once full
module lhfs_log
  import lhfs_pkg::*;
#(
  parameter int DEPTH = LOG_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  lhfs_log_if.store lg
);
  logic [31:0] mem_r [DEPTH];
  logic [11:0] cnt_r;
  wire full = (cnt_r == 12'(DEPTH));
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Writes beyond capacity are dropped rather than overwrite history
  always_ff @(posedge hclk) begin
    if (lg.wr && !full) begin
      mem_r[cnt_r] <= lg.wdata;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 12'h000;
    end else if (lg.wr && !full) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end
  assign lg.count = cnt_r;
  assign lg.rdata = (lg.ridx < cnt_r) ? mem_r[lg.ridx] : 32'h0000_0000;
  property p_log_full_hold;
    @(posedge hclk) disable iff (!hresetn) full |=> cnt_r == 12'(DEPTH);
  endproperty
  a_log_full_hold: assert property (p_log_full_hold) else $error("log count moved when full");
endmodule
`default_nettype wire

// *** lhfs_logic_sched.sv ***
`timescale 1ns/1ns
`default_nettype none
// Logic page scheduler: a new cycle starts on a tick once the last is done, pages run in order
module lhfs_logic_sched
  import lhfs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cycle_tick,
  input wire logic [7:0] page_total,
  input wire logic page_done,
  output logic page_run,
  output logic [7:0] page_idx,
  output logic all_done
);
  logic [7:0] idx_r;
  logic done_r;
  logic run_r;
  // ------------------------------------------------------------
  // Page sequencing
  // ------------------------------------------------------------
  // A page that ends on a tick still counts; the unfinished index carries over
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_r <= 8'h00;
      done_r <= 1'b0;
      run_r <= 1'b0;
    end else if (cycle_tick && done_r) begin
      run_r <= (page_total != 8'h00);
      idx_r <= 8'h00;
      done_r <= 1'b0;
    end else if (run_r && page_done) begin
      if (idx_r + 8'h01 >= page_total) begin
        done_r <= 1'b1;
        run_r <= 1'b0;
      end else begin
        idx_r <= idx_r + 8'h01;
      end
    end else if (cycle_tick) begin
      run_r <= (page_total != 8'h00);
    end
  end
  assign page_run = run_r && !done_r;
  assign page_idx = idx_r;
  assign all_done = done_r;
  property p_restart_only_on_tick;
    @(posedge hclk) disable iff (!hresetn)
      (idx_r != 8'h00) ##1 (idx_r == 8'h00) |-> $past(cycle_tick) && $past(done_r);
  endproperty
  a_restart_only_on_tick: assert property (p_restart_only_on_tick) else $error("early restart");
  property p_ordered;
    @(posedge hclk) disable iff (!hresetn)
      run_r && page_done && !cycle_tick && (idx_r + 8'h01 < page_total) |=> idx_r == $past(idx_r) + 8'h01;
  endproperty
  a_ordered: assert property (p_ordered) else $error("page order broken");
endmodule
`default_nettype wire

// *** lhfs_supervisor.sv ***
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
module lhfs_supervisor
  import lhfs_pkg::*;
#(
  parameter int HB_CYCLES = HB_CYC,
  parameter int RING_TMO_CYCLES = RING_TMO_CYC,
  parameter int LOGIC_CYCLES = LOGIC_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic ring_tx_a,
  output logic ring_tx_b,
  output logic [31:0] ring_tx_time,
  input wire logic ring_rx_a,
  input wire logic ring_rx_b,
  input wire logic [FLT_W-1:0] fault_in,
  input wire logic [ALM_W-1:0] alarm_in,
  input wire logic [NDEV-1:0] dev_status,
  input wire logic reset_button,
  input wire logic page_done,
  output logic page_run,
  output logic [7:0] page_idx,
  output logic general_fault_indicator,
  output logic ring_fault_indicator,
  output logic [ALM_W-1:0] alarm_indicator,
  output logic trouble_tone,
  output logic alarm_tone,
  output logic trouble_relay,
  output logic [NDEV-1:0] dev_offline,
  output logic [FLT_W-1:0] disp_fault,
  output logic [ALM_W-1:0] disp_alarm
);
  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic ap_wr_r;
  logic ap_rd_r;
  logic [7:0] ap_addr_r;
  logic [31:0] ctrl_r;
  logic [31:0] time_r;
  logic [11:0] logidx_r;
  logic [7:0] pages_r;
  logic [31:0] hrdata_r;
  wire ap_valid = hsel && hready && htrans[1];
  wire ap_in_wr = ap_valid && hwrite;
  wire ap_in_rd = ap_valid && !hwrite;
  wire wr_ctrl = ap_wr_r && (ap_addr_r == ADDR_CTRL);
  wire wr_time = ap_wr_r && (ap_addr_r == ADDR_TIME);
  wire wr_logidx = ap_wr_r && (ap_addr_r == ADDR_LOGIDX);
  wire wr_pages = ap_wr_r && (ap_addr_r == ADDR_PAGES);
  wire redund_en = ctrl_r[CTRL_REDUND_BIT];
  wire dir_sel = ctrl_r[CTRL_DIR_BIT];
  // Address phase captured; slave never inserts wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else begin
      ap_wr_r <= ap_in_wr;
      ap_rd_r <= ap_in_rd;
      ap_addr_r <= haddr[7:0];
    end
  end
  // Writable registers
  logic [31:0] time_nxt;
  logic sec_tick;
  assign time_nxt = wr_time ? hwdata : (sec_tick ? time_r + 32'h0000_0001 : time_r);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
      time_r <= 32'h0000_0000;
      logidx_r <= 12'h000;
      pages_r <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata;
      end
      time_r <= time_nxt;
      if (wr_logidx) begin
        logidx_r <= hwdata[11:0];
      end
      if (wr_pages) begin
        pages_r <= hwdata[7:0];
      end
    end
  end
  // ------------------------------------------------------------
  // Heartbeat generation and ring continuity
  // ------------------------------------------------------------
  logic [31:0] hb_cnt_r;
  logic [9:0] hb_num_r;
  logic hb_pulse_r;
  logic [31:0] tmo_r;
  logic ring_fail_r;
  lhfs_hb_e hb_st_r;
  wire hb_fire = (hb_cnt_r == 32'(HB_CYCLES - 1));
  // Return port depends on launch direction
  wire hb_back = dir_sel ? ring_rx_a : ring_rx_b;
  assign sec_tick = hb_fire && (hb_num_r == 10'(HB_PER_SEC - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hb_cnt_r <= 32'h0000_0000;
      hb_num_r <= 10'h000;
      hb_pulse_r <= 1'b0;
    end else begin
      hb_cnt_r <= hb_fire ? 32'h0000_0000 : hb_cnt_r + 32'h0000_0001;
      hb_pulse_r <= hb_fire;
      if (hb_fire) begin
        hb_num_r <= sec_tick ? 10'h000 : hb_num_r + 10'h001;
      end
    end
  end
  // Both ports launch; the time word is stamped on each beat
  assign ring_tx_a = hb_pulse_r;
  assign ring_tx_b = hb_pulse_r;
  assign ring_tx_time = time_r;
  // Continuity checker: beat must come back before the timeout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hb_st_r <= LHFS_HB_IDLE;
      tmo_r <= 32'h0000_0000;
      ring_fail_r <= 1'b0;
    end else begin
      case (hb_st_r)
        LHFS_HB_IDLE: begin
          if (hb_pulse_r) begin
            hb_st_r <= LHFS_HB_WAIT;
            tmo_r <= 32'h0000_0000;
          end
        end
        LHFS_HB_WAIT: begin
          if (hb_back) begin
            hb_st_r <= LHFS_HB_IDLE;
            ring_fail_r <= 1'b0;
          end else if (tmo_r == 32'(RING_TMO_CYCLES - 1)) begin
            hb_st_r <= LHFS_HB_FAIL;
            ring_fail_r <= 1'b1;
          end else begin
            tmo_r <= tmo_r + 32'h0000_0001;
          end
        end
        default: begin
          hb_st_r <= LHFS_HB_IDLE;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // Device offline supervision
  // ------------------------------------------------------------
  // Each device must report within the longest status interval
  logic [15:0] dev_tmo_r [NDEV];
  logic [NDEV-1:0] offline_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NDEV; i++) begin
        dev_tmo_r[i] <= 16'h0000;
      end
      offline_r <= '0;
    end else begin
      for (int i = 0; i < NDEV; i++) begin
        if (dev_status[i]) begin
          dev_tmo_r[i] <= 16'h0000;
          offline_r[i] <= 1'b0;
        end else if (hb_fire) begin
          if (dev_tmo_r[i] == 16'(DEV_TMO_TICKS - 1)) begin
            offline_r[i] <= 1'b1;
          end else begin
            dev_tmo_r[i] <= dev_tmo_r[i] + 16'h0001;
          end
        end
      end
    end
  end
  assign dev_offline = offline_r;
  // ------------------------------------------------------------
  // Fault and alarm latches
  // ------------------------------------------------------------
  logic [FLT_W-1:0] flt_r;
  logic [ALM_W-1:0] alm_r;
  logic [FLT_W-1:0] flt_live;
  always_comb begin
    flt_live = fault_in;
    flt_live[FLT_RING] = fault_in[FLT_RING] | ring_fail_r;
    flt_live[FLT_OFFLINE] = fault_in[FLT_OFFLINE] | (|offline_r);
    flt_live[FLT_REDUND] = fault_in[FLT_REDUND] & redund_en;
  end
  // Reset accepted only when nothing on the display is still live
  wire conds_clear = (flt_live == '0) && (alarm_in == '0);
  wire do_clear = reset_button && conds_clear;
  // Set beats clear, so a live alarm survives the reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_r <= '0;
      alm_r <= '0;
    end else begin
      flt_r <= (do_clear ? '0 : flt_r) | flt_live;
      alm_r <= (do_clear ? '0 : alm_r) | alarm_in;
    end
  end
  // Annunciation: any latched fault drops the relay
  wire any_fault = |flt_r;
  assign disp_fault = flt_r;
  assign disp_alarm = alm_r;
  assign general_fault_indicator = any_fault;
  assign ring_fault_indicator = flt_r[FLT_RING];
  assign trouble_tone = any_fault;
  assign trouble_relay = !any_fault;
  assign alarm_indicator = alm_r;
  assign alarm_tone = |alm_r;
  // ------------------------------------------------------------
  // Event log and logic scheduler
  // ------------------------------------------------------------
  lhfs_log_if lgi();
  logic [FLT_W-1:0] flt_q_r;
  logic [ALM_W-1:0] alm_q_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_q_r <= '0;
      alm_q_r <= '0;
    end else begin
      flt_q_r <= flt_r;
      alm_q_r <= alm_r;
    end
  end
  // Any change of the latched conditions, set or clear, creates a time-stamped record
  assign lgi.wr = (flt_r != flt_q_r) || (alm_r != alm_q_r);
  assign lgi.wdata = {time_r[18:0], flt_r, alm_r};
  assign lgi.ridx = logidx_r;
  lhfs_log u_log (
    .hclk(hclk),
    .hresetn(hresetn),
    .lg(lgi)
  );
  logic [31:0] lc_cnt_r;
  wire lc_tick = (lc_cnt_r == 32'(LOGIC_CYCLES - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lc_cnt_r <= 32'h0000_0000;
    end else begin
      lc_cnt_r <= lc_tick ? 32'h0000_0000 : lc_cnt_r + 32'h0000_0001;
    end
  end
  logic all_done;
  lhfs_logic_sched u_sched (
    .hclk(hclk),
    .hresetn(hresetn),
    .cycle_tick(lc_tick),
    .page_total(pages_r),
    .page_done(page_done),
    .page_run(page_run),
    .page_idx(page_idx),
    .all_done(all_done)
  );
  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  logic [31:0] rd_mux;
  wire [31:0] status_w = {28'h0000000, all_done, hb_st_r, ring_fail_r};
  always_comb begin
    if (ap_addr_r == ADDR_CTRL) begin
      rd_mux = ctrl_r;
    end else if (ap_addr_r == ADDR_STATUS) begin
      rd_mux = status_w;
    end else if (ap_addr_r == ADDR_FAULT) begin
      rd_mux = {27'h0000000, flt_r};
    end else if (ap_addr_r == ADDR_ALARM) begin
      rd_mux = {24'h000000, alm_r};
    end else if (ap_addr_r == ADDR_TIME) begin
      rd_mux = time_r;
    end else if (ap_addr_r == ADDR_LOGCNT) begin
      rd_mux = {20'h00000, lgi.count};
    end else if (ap_addr_r == ADDR_LOGIDX) begin
      rd_mux = {20'h00000, logidx_r};
    end else if (ap_addr_r == ADDR_LOGDATA) begin
      rd_mux = lgi.rdata;
    end else if (ap_addr_r == ADDR_PAGES) begin
      rd_mux = {24'h000000, pages_r};
    end else if (ap_addr_r == ADDR_OFFLINE) begin
      rd_mux = {24'h000000, offline_r};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end
  assign hrdata = rd_mux;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_relay_vs_fault;
    @(posedge hclk) disable iff (!hresetn) trouble_relay == (flt_r == '0);
  endproperty
  a_relay_vs_fault: assert property (p_relay_vs_fault) else $error("relay mismatch");
  property p_ring_led;
    @(posedge hclk) disable iff (!hresetn) ring_fault_indicator |-> general_fault_indicator;
  endproperty
  a_ring_led: assert property (p_ring_led) else $error("ring led without general");
  property p_no_redund;
    @(posedge hclk) disable iff (!hresetn) !redund_en && !flt_r[FLT_REDUND] |=> !flt_r[FLT_REDUND] || $past(redund_en);
  endproperty
  a_no_redund: assert property (p_no_redund) else $error("redundancy fault without pair");
  property p_latch;
    @(posedge hclk) disable iff (!hresetn) flt_r != '0 && !do_clear |=> (flt_r & $past(flt_r)) == $past(flt_r);
  endproperty
  a_latch: assert property (p_latch) else $error("fault dropped");
  property p_ignore_reset;
    @(posedge hclk) disable iff (!hresetn) reset_button && !conds_clear |=> (alm_r & $past(alm_r)) == $past(alm_r);
  endproperty
  a_ignore_reset: assert property (p_ignore_reset) else $error("reset not ignored");
  property p_alarm_survive;
    @(posedge hclk) disable iff (!hresetn) alarm_in != '0 |=> (alm_r & $past(alarm_in)) == $past(alarm_in);
  endproperty
  a_alarm_survive: assert property (p_alarm_survive) else $error("active alarm lost");
  property p_alarm_tone;
    @(posedge hclk) disable iff (!hresetn) alarm_in != '0 |=> alarm_tone;
  endproperty
  a_alarm_tone: assert property (p_alarm_tone) else $error("no alarm tone");
  property p_hb_pair;
    @(posedge hclk) disable iff (!hresetn) hb_fire |=> ring_tx_a && ring_tx_b ##1 !ring_tx_a;
  endproperty
  a_hb_pair: assert property (p_hb_pair) else $error("heartbeat not sent both ways");
  property p_ring_fail;
    @(posedge hclk) disable iff (!hresetn)
      hb_st_r == LHFS_HB_WAIT && !hb_back && tmo_r == 32'(RING_TMO_CYCLES - 1) |=> ring_fail_r;
  endproperty
  a_ring_fail: assert property (p_ring_fail) else $error("ring failure missed");
  c_fault: cover property (@(posedge hclk) disable iff (!hresetn) !trouble_relay);
  c_alarm: cover property (@(posedge hclk) disable iff (!hresetn) alarm_tone);
  c_clear: cover property (@(posedge hclk) disable iff (!hresetn) do_clear && any_fault);
  c_ring: cover property (@(posedge hclk) disable iff (!hresetn) ring_fault_indicator);
endmodule
`default_nettype wire

// *** lhfs_ring_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Field devices on the ring
// ----------------------------------------
module lhfs_ring_model #(
  parameter int STAT_CYC = 100,
  parameter int ISO_CAP = 1000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ring_tx_a,
  input wire logic ring_tx_b,
  input wire logic cut_ab,
  input wire logic slow,
  output logic ring_rx_a,
  output logic ring_rx_b,
  output logic [7:0] dev_status
);
  logic [5:0] a2b_r;
  logic [5:0] b2a_r;
  logic [7:0] stat_cnt_r;
  logic [7:0] quiet_r;
  logic [9:0] iso_age_r;
  logic iso_side_r;
  // Silent device opens one side, swapping sides until the cap ends isolation
  wire isolating = (quiet_r == 8'hff) && (iso_age_r != 10'(ISO_CAP));
  // Beats travel a short delay line; a cut segment stops only a-to-b beats
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a2b_r <= '0;
      b2a_r <= '0;
      stat_cnt_r <= '0;
      quiet_r <= '0;
      iso_age_r <= '0;
      iso_side_r <= 1'b0;
    end else begin
      a2b_r <= {a2b_r[4:0], ring_tx_a & ~cut_ab & ~(isolating & iso_side_r)};
      b2a_r <= {b2a_r[4:0], ring_tx_b & ~(isolating & ~iso_side_r)};
      quiet_r <= (a2b_r[2] | b2a_r[2]) ? 8'h00 : quiet_r + 8'(quiet_r != 8'hff);
      iso_age_r <= (quiet_r == 8'h00) ? 10'h000 : iso_age_r + 10'(isolating);
      iso_side_r <= iso_side_r ^ (isolating && iso_age_r[3:0] == 4'hf);
      stat_cnt_r <= (stat_cnt_r == 8'(STAT_CYC - 1)) ? 8'h00 : stat_cnt_r + 8'h01;
    end
  end
  // Slow mode stands for a long ring, yet stays inside the return timeout
  assign ring_rx_b = slow ? a2b_r[4] : a2b_r[1];
  assign ring_rx_a = slow ? b2a_r[4] : b2a_r[1];
  // Every device reports once a period while the ring is not isolating, well inside one second
  assign dev_status = (stat_cnt_r == 8'h00 && !isolating) ? 8'hff : 8'h00;
endmodule
`default_nettype wire

// *** tb_loop_heartbeat_fault_supervisor.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_loop_heartbeat_fault_supervisor
  import lhfs_pkg::*;
;
  // ----------------------------------------
  // Shortened counts and stimulus table
  // ----------------------------------------
  localparam int HB = 20;
  localparam int LC = 50;
  typedef struct {
    logic [FLT_W-1:0] f;
    logic [ALM_W-1:0] a;
    logic [FLT_W-1:0] ef;
    logic [ALM_W-1:0] ea;
  } lhfs_row_s;
  // Redundancy row expects nothing: the pair bit is clear
  lhfs_row_s rows [7] = '{'{5'h01, 8'h00, 5'h01, 8'h00}, '{5'h02, 8'h00, 5'h02, 8'h00},
    '{5'h04, 8'h00, 5'h04, 8'h00}, '{5'h08, 8'h00, 5'h00, 8'h00},
    '{5'h10, 8'h00, 5'h10, 8'h00}, '{5'h00, 8'h01, 5'h00, 8'h01},
    '{5'h00, 8'h80, 5'h00, 8'h80}};
  logic hclk, hresetn, hsel, hwrite, hready, hresp, reset_button, page_done, page_run;
  logic [31:0] haddr, hwdata, hrdata, ring_tx_time, rd, t0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic ring_tx_a, ring_tx_b, ring_rx_a, ring_rx_b, cut_ab, slow;
  logic [FLT_W-1:0] fault_in, disp_fault;
  logic [ALM_W-1:0] alarm_in, alarm_indicator, disp_alarm;
  logic [NDEV-1:0] dev_status, dev_offline;
  logic [7:0] page_idx;
  logic general_fault_indicator, ring_fault_indicator, trouble_tone, alarm_tone, trouble_relay;
  int fails, comparisons, n, k, kb, nlog;

  lhfs_supervisor #(.HB_CYCLES(HB), .RING_TMO_CYCLES(8), .LOGIC_CYCLES(LC)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout(hready), .hresp, .ring_tx_a, .ring_tx_b, .ring_tx_time, .ring_rx_a,
    .ring_rx_b, .fault_in, .alarm_in, .dev_status, .reset_button, .page_done, .page_run,
    .page_idx, .general_fault_indicator, .ring_fault_indicator, .alarm_indicator,
    .trouble_tone, .alarm_tone, .trouble_relay, .dev_offline, .disp_fault, .disp_alarm);
  lhfs_ring_model u_ring (.hclk, .hresetn, .ring_tx_a, .ring_tx_b, .cut_ab, .slow,
    .ring_rx_a, .ring_rx_b, .dev_status);

  // Free-running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %0s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Outputs are read at the falling edge, where they have settled
  task automatic look(input int c);
    repeat (c) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic tmo(input logic bad);
    if (bad) begin
      fails++;
      $display("wrong value at %0t: wait timed out", $time);
      print_verdict();
    end
  endtask
  // Single word transfer; hready is sampled at each falling edge, never assumed
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    logic ok;
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr, hsize} <= {1'b1, 2'b10, wr, a, 3'b010};
    n = 0;
    do begin
      @(negedge hclk);
      ok = hready;
      @(posedge hclk);
      n++;
    end while (ok !== 1'b1 && n < 50);
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    do begin
      @(negedge hclk);
      ok = hready;
      rd = hrdata;
      @(posedge hclk);
      n++;
    end while (ok !== 1'b1 && n < 100);
    tmo(n >= 100);
  endtask
  task automatic press();
    @(posedge hclk);
    reset_button <= 1'b1;
    @(posedge hclk);
    reset_button <= 1'b0;
    look(3);
  endtask
  // A page finishes only while evaluation is allowed
  task automatic step_page();
    n = 0;
    do begin
      look(0);
      n++;
    end while (page_run !== 1'b1 && n < 3 * LC);
    tmo(n >= 3 * LC);
    @(posedge hclk);
    page_done <= 1'b1;
    @(posedge hclk);
    page_done <= 1'b0;
    look(1);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hsize, hwdata, reset_button, page_done} = '0;
    {fault_in, alarm_in, cut_ab, slow} = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    look(1);
    chk(trouble_relay, 1, "relay idle");
    ahb(0, ADDR_CTRL, 0);
    chk(rd, CTRL_RESET, "ctrl reset");
    ahb(1, 32'h40, 32'hffff_ffff);
    ahb(0, 32'h40, 0);
    chk(rd, 0, "unmapped");
    $display("test registers done");
    // Table rows: pulse one condition, check the latch, then clear it
    foreach (rows[i]) begin
      k = ((rows[i].ef | rows[i].ea) != 0) ? 1 : 0;
      @(posedge hclk);
      {fault_in, alarm_in} <= {rows[i].f, rows[i].a};
      @(posedge hclk);
      {fault_in, alarm_in} <= '0;
      look(3);
      chk(disp_fault, rows[i].ef, "fault latch");
      chk(general_fault_indicator, |rows[i].ef, "general");
      chk(ring_fault_indicator, rows[i].ef[FLT_RING], "ring led");
      chk(trouble_tone, |rows[i].ef, "trouble tone");
      chk(trouble_relay, ~|rows[i].ef, "relay");
      chk(disp_alarm, rows[i].ea, "alarm latch");
      chk(alarm_indicator, rows[i].ea, "alarm led");
      chk(alarm_tone, |rows[i].ea, "alarm tone");
      nlog += k;
      ahb(0, ADDR_LOGCNT, 0);
      chk(rd, nlog, "log count");
      nlog += k;
      press();
      chk({disp_fault, disp_alarm}, 0, "cleared");
      $display("row %0d done", i);
    end
    ahb(1, ADDR_LOGIDX, 0);
    ahb(0, ADDR_LOGDATA, 0);
    chk(rd, 32'h0000_0100, "first record");
    // Redundant pair: the redundancy condition now latches
    ahb(1, ADDR_CTRL, 32'h1);
    @(posedge hclk);
    fault_in <= 5'h08;
    @(posedge hclk);
    fault_in <= 5'h00;
    look(3);
    chk(disp_fault, 5'h08, "redundancy");
    press();
    ahb(1, ADDR_CTRL, 0);
    // A live alarm blocks the reset press and survives it
    @(posedge hclk);
    {fault_in, alarm_in} <= {5'h01, 8'h04};
    @(posedge hclk);
    fault_in <= 5'h00;
    press();
    chk(disp_fault, 5'h01, "press ignored");
    chk(disp_alarm, 8'h04, "alarm kept");
    @(posedge hclk);
    alarm_in <= 8'h00;
    press();
    chk({disp_fault, disp_alarm}, 0, "press taken");
    $display("test latches done");
    // Break the a-to-b path, then turn the check round
    @(posedge hclk);
    cut_ab <= 1'b1;
    look(3 * HB);
    chk(ring_fault_indicator, 1, "ring fault");
    chk(trouble_relay, 0, "relay ring");
    ahb(0, ADDR_STATUS, 0);
    chk(rd[0], 1, "ring fail");
    ahb(1, ADDR_CTRL, 32'h2);
    look(3 * HB);
    ahb(0, ADDR_STATUS, 0);
    chk(rd[0], 0, "reverse ok");
    press();
    chk(ring_fault_indicator, 0, "ring cleared");
    // Mend the cut before swapping back, so no beat in flight goes unseen
    @(posedge hclk);
    cut_ab <= 1'b0;
    look(HB);
    ahb(1, ADDR_CTRL, 0);
    @(posedge hclk);
    slow <= 1'b1;
    look(3 * HB);
    chk(ring_fault_indicator, 0, "slow return");
    @(posedge hclk);
    slow <= 1'b0;
    $display("test ring done");
    // One time step spans exactly one second of beats on both ports
    t0 = ring_tx_time;
    n = 0;
    do begin
      look(0);
      n++;
    end while (ring_tx_time === t0 && n < 30000);
    {t0, k, kb, n} = {ring_tx_time, 96'h0};
    do begin
      look(0);
      k += int'(ring_tx_a);
      kb += int'(ring_tx_b);
      n++;
    end while (ring_tx_time === t0 && n < 30000);
    tmo(n >= 30000);
    chk(k, HB_PER_SEC, "beats a");
    chk(kb, HB_PER_SEC, "beats b");
    chk(ring_tx_time, t0 + 32'h1, "time step");
    ahb(0, ADDR_TIME, 0);
    chk(rd, ring_tx_time, "time reg");
    chk(dev_offline, 0, "online");
    $display("test heartbeat done");
    // Three pages: order, resume across cycles, restart after completion
    ahb(1, ADDR_PAGES, 32'h3);
    step_page();
    chk(page_idx, 1, "page one");
    look(2 * LC);
    chk(page_idx, 1, "resume");
    step_page();
    chk(page_idx, 2, "page two");
    step_page();
    ahb(0, ADDR_STATUS, 0);
    chk(rd[3], 1, "all done");
    look(2 * LC);
    chk(page_idx, 0, "restart");
    $display("test scheduler done");
    print_verdict();
  end
endmodule
`default_nettype wire
